// File: common/dsp_word_map.svh
// Register offsets, field positions and reset values of the instruction word generator
`ifndef DSP_WORD_MAP_SVH
`define DSP_WORD_MAP_SVH

// Word offsets on the register bus
`define REG_CTRL          8'h00
`define REG_CUSTOM        8'h04
`define REG_INPUT         8'h08
`define REG_WORD          8'h0C
`define REG_STATUS        8'h10

// Control register fields
`define CTRL_GEN_LSB      0
`define CTRL_PRESET_LSB   4
`define CTRL_NEGATE_BIT   8

// Custom register fields; XY, Z, carry bit and carry select are placed where they land in the word
`define CUS_XY_LSB        0
`define CUS_Z_LSB         4
`define CUS_SUB_BIT       7
`define CUS_CBIT_BIT      11
`define CUS_CSEL_LSB      12
`define CUS_W_LSB         16

// Input-stage register fields
`define INP_PREADD_LSB    0
`define INP_BREG_BIT      4
`define INP_PSEL_BIT      8
`define INP_AMUL_BIT      9
`define INP_BMUL_BIT      10
`define INP_AREG_BIT      11

// Status register fields
`define STAT_WIDTH_LSB    0
`define STAT_CIN_BIT      8
`define STAT_CPORT_BIT    9

// Word widths per generation
`define WIDTH_FIRST       5'h0F
`define WIDTH_SECOND      5'h14
`define WIDTH_THIRD       5'h16

// Reset values
`define RST_CTRL          32'h0000_0000
`define RST_CUSTOM        32'h0000_0000
`define RST_INPUT         32'h0000_0000

`endif

// File: common/dsp_word_pkg.sv
// Types shared by the instruction word generator modules
package dsp_word_pkg;
  typedef enum logic [1:0] {GEN_FIRST = 2'h0, GEN_SECOND = 2'h1, GEN_THIRD = 2'h3} gen_t;
  typedef enum logic [2:0] {
    OP_C_PROD = 3'h0, OP_CASC_PROD = 3'h1, OP_P_PROD = 3'h2, OP_PROD = 3'h3,
    OP_C_PLUS_AB = 3'h4, OP_C_MINUS_AB = 3'h5, OP_C_ONLY = 3'h6, OP_CUSTOM = 3'h7
  } preset_t;
  typedef enum logic [3:0] {
    XY_ZERO = 4'h0, XY_P = 4'h1, XY_AB = 4'h2, XY_PROD = 4'h3,
    XY_C = 4'h4, XY_P_PLUS_C = 4'h5, XY_AB_PLUS_C = 4'h6
  } xy_t;
  typedef enum logic [2:0] {
    Z_ZERO = 3'h0, Z_CASCADE = 3'h1, Z_P = 3'h2, Z_C = 3'h3,
    Z_CASCADE_SHR17 = 3'h4, Z_P_SHR17 = 3'h5
  } z_t;
  typedef enum logic [3:0] {ALU_ADD = 4'h0, ALU_SUB = 4'h3} alu_t;
  typedef enum logic [2:0] {
    CY_CONST = 3'h0, CY_EXTERNAL = 3'h1, CY_ROUND_CASCADE = 3'h2, CY_ROUND_P = 3'h3,
    CY_WIDE_PARALLEL = 3'h4, CY_WIDE_SEQUENTIAL = 3'h5, CY_ROUND_PROD = 3'h6
  } carry_t;
  typedef enum logic [1:0] {W_ZERO = 2'h0, W_P = 2'h1, W_ROUNDING = 2'h2, W_C = 2'h3} w_t;
endpackage : dsp_word_pkg

// File: common/dsp_word_cfg_if.sv
// Field settings passed from the register side to the word encoder
`timescale 1ns/1ps
interface dsp_word_cfg_if;
  dsp_word_pkg::gen_t   gen;
  dsp_word_pkg::xy_t    xy;
  dsp_word_pkg::z_t     z;
  dsp_word_pkg::alu_t   alu;
  dsp_word_pkg::carry_t carry_sel;
  logic                 carry_bit;
  dsp_word_pkg::w_t     w;
  logic [3:0]           preadd_fn;
  logic                 preadd_operand_select;
  logic                 mult_a_input_select;
  logic                 mult_b_input_select;
  logic                 a_stage;
  logic                 b_stage;
  logic                 cin;
  logic [21:0]          word;
  modport src (output gen, xy, z, alu, carry_sel, carry_bit, w, preadd_fn, preadd_operand_select,
               mult_a_input_select, mult_b_input_select, a_stage, b_stage, cin, input word);
  modport enc (input gen, xy, z, alu, carry_sel, carry_bit, w, preadd_fn, preadd_operand_select,
               mult_a_input_select, mult_b_input_select, a_stage, b_stage, cin, output word);
endinterface : dsp_word_cfg_if

// File: rtl/dsp_word_encoder.sv
// Packs the field settings into the generation-specific instruction word
`timescale 1ns/1ps
module dsp_word_encoder (
  // Field settings in, packed word out
  dsp_word_cfg_if.enc cfg
);
  logic        cbit;
  logic [14:0] base_word;
  logic [4:0]  second_stage;
  logic [6:0]  third_stage;

  // External carry replaces the stored bit at position 11
  assign cbit = (cfg.carry_sel == dsp_word_pkg::CY_EXTERNAL) ? cfg.cin : cfg.carry_bit;

  // Common low fifteen bits
  assign base_word = {cfg.carry_sel, cbit, cfg.alu, cfg.z, cfg.xy};

  // Input-stage bits: pre-adder function and B stage
  assign second_stage = {cfg.preadd_fn, cfg.b_stage};

  // Newest layout: W source, pre-adder operand, multiplier inputs, A and B stage
  assign third_stage = {cfg.w, cfg.preadd_operand_select, cfg.mult_a_input_select,
                        cfg.mult_b_input_select, cfg.a_stage, cfg.b_stage};

  // Unused upper bits stay zero so the word width is exact
  always_comb begin
    unique case (cfg.gen)
      dsp_word_pkg::GEN_THIRD:  cfg.word = {third_stage, base_word};
      dsp_word_pkg::GEN_SECOND: cfg.word = {2'h0, second_stage, base_word};
      default:                  cfg.word = {7'h00, base_word};
    endcase
  end
endmodule : dsp_word_encoder

// File: rtl/dsp_slice_instruction_word_gen.sv
// Instruction word generator for a multiply-accumulate slice, with Wishbone register access
`timescale 1ns/1ps
`include "dsp_word_map.svh"
module dsp_slice_instruction_word_gen (
  // Clock, reset and enable
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        ce,
  // Wishbone classic slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Carry pin from outside this clock domain
  input  wire logic        carry_in_pin,
  // Slice control outputs
  output logic      [21:0] instr_word,
  output logic      [4:0]  word_width,
  output logic             carry_port_used,
  output logic             mult_negate
);

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction : lane_merge

  // Generation code legalisation; unused code falls back to the first generation
  function automatic dsp_word_pkg::gen_t gen_legal(input logic [1:0] code);
    dsp_word_pkg::gen_t g;
    g = dsp_word_pkg::GEN_FIRST;
    if (code == 2'h1) begin
      g = dsp_word_pkg::GEN_SECOND;
    end
    if (code == 2'h3) begin
      g = dsp_word_pkg::GEN_THIRD;
    end
    return g;
  endfunction : gen_legal

  // Word width for a generation
  function automatic logic [4:0] gen_width(input dsp_word_pkg::gen_t g);
    logic [4:0] w;
    w = `WIDTH_FIRST;
    if (g == dsp_word_pkg::GEN_SECOND) begin
      w = `WIDTH_SECOND;
    end
    if (g == dsp_word_pkg::GEN_THIRD) begin
      w = `WIDTH_THIRD;
    end
    return w;
  endfunction : gen_width

  // Stored configuration registers
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic [31:0] custom_q;
  logic [31:0] custom_d;
  logic [31:0] input_q;
  logic [31:0] input_d;

  // Bus handshake
  logic        ack_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        bus_req;
  logic        wr_ctrl;
  logic        wr_custom;
  logic        wr_input;
  logic        hit_known;

  // Carry pin synchroniser
  logic        cin_meta_q;
  logic        cin_sync_q;

  // Output word registers
  logic [21:0] word_q;
  logic [4:0]  width_q;
  logic        cport_q;
  logic        negate_q;

  // Decoded settings
  dsp_word_pkg::gen_t    gen_sel;
  dsp_word_pkg::preset_t preset_sel;
  logic                  is_custom;
  dsp_word_pkg::xy_t     xy_p;
  dsp_word_pkg::z_t      z_p;
  dsp_word_pkg::alu_t    alu_p;
  dsp_word_pkg::xy_t     xy_c;
  dsp_word_pkg::z_t      z_c;
  dsp_word_pkg::carry_t  csel_c;
  dsp_word_pkg::w_t      w_c;
  logic [31:0]           ctrl_wr;
  logic [31:0]           custom_wr;
  logic [31:0]           input_wr;

  dsp_word_cfg_if cfg ();

  // Request decode: a new request is one not yet acknowledged
  assign bus_req   = cyc_i & stb_i & ~ack_q;
  assign wr_ctrl   = bus_req & we_i & (adr_i == `REG_CTRL);
  assign wr_custom = bus_req & we_i & (adr_i == `REG_CUSTOM);
  assign wr_input  = bus_req & we_i & (adr_i == `REG_INPUT);
  assign hit_known = (adr_i == `REG_CTRL) | (adr_i == `REG_CUSTOM) | (adr_i == `REG_INPUT) |
                     (adr_i == `REG_WORD) | (adr_i == `REG_STATUS);

  // Merged write values before field legalisation
  assign ctrl_wr   = lane_merge(ctrl_q, dat_i, sel_i);
  assign custom_wr = lane_merge(custom_q, dat_i, sel_i);
  assign input_wr  = lane_merge(input_q, dat_i, sel_i);

  // Control register keeps only legal generation codes
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = 32'h0000_0000;
      ctrl_d[`CTRL_GEN_LSB +: 2]    = gen_legal(ctrl_wr[`CTRL_GEN_LSB +: 2]);
      ctrl_d[`CTRL_PRESET_LSB +: 3] = ctrl_wr[`CTRL_PRESET_LSB +: 3];
      ctrl_d[`CTRL_NEGATE_BIT]      = ctrl_wr[`CTRL_NEGATE_BIT];
    end
  end

  // Custom register: out-of-range source codes are refused field by field
  always_comb begin
    custom_d = custom_q;
    if (wr_custom) begin
      custom_d = 32'h0000_0000;
      custom_d[`CUS_XY_LSB +: 4] = (custom_wr[`CUS_XY_LSB +: 4] > 4'h6) ?
                                   custom_q[`CUS_XY_LSB +: 4] : custom_wr[`CUS_XY_LSB +: 4];
      custom_d[`CUS_Z_LSB +: 3]  = (custom_wr[`CUS_Z_LSB +: 3] > 3'h5) ?
                                   custom_q[`CUS_Z_LSB +: 3] : custom_wr[`CUS_Z_LSB +: 3];
      custom_d[`CUS_SUB_BIT]     = custom_wr[`CUS_SUB_BIT];
      custom_d[`CUS_CBIT_BIT]    = custom_wr[`CUS_CBIT_BIT];
      custom_d[`CUS_CSEL_LSB +: 3] = (custom_wr[`CUS_CSEL_LSB +: 3] == 3'h7) ?
                                     custom_q[`CUS_CSEL_LSB +: 3] : custom_wr[`CUS_CSEL_LSB +: 3];
      custom_d[`CUS_W_LSB +: 2]  = custom_wr[`CUS_W_LSB +: 2];
    end
  end

  // Input-stage register; pre-adder function codes above nine are refused
  always_comb begin
    input_d = input_q;
    if (wr_input) begin
      input_d = 32'h0000_0000;
      input_d[`INP_PREADD_LSB +: 4] = (input_wr[`INP_PREADD_LSB +: 4] > 4'h9) ?
                                      input_q[`INP_PREADD_LSB +: 4] : input_wr[`INP_PREADD_LSB +: 4];
      input_d[`INP_BREG_BIT] = input_wr[`INP_BREG_BIT];
      input_d[`INP_PSEL_BIT] = input_wr[`INP_PSEL_BIT];
      input_d[`INP_AMUL_BIT] = input_wr[`INP_AMUL_BIT];
      input_d[`INP_BMUL_BIT] = input_wr[`INP_BMUL_BIT];
      input_d[`INP_AREG_BIT] = input_wr[`INP_AREG_BIT];
    end
  end

  // Read data; unmapped offsets answer with zero rather than stalling the master
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (adr_i)
      `REG_CTRL:   rdata_d = ctrl_q;
      `REG_CUSTOM: rdata_d = custom_q;
      `REG_INPUT:  rdata_d = input_q;
      `REG_WORD:   rdata_d = {10'h000, word_q};
      `REG_STATUS: begin
        rdata_d[`STAT_WIDTH_LSB +: 5] = width_q;
        rdata_d[`STAT_CIN_BIT]        = cin_sync_q;
        rdata_d[`STAT_CPORT_BIT]      = cport_q;
      end
      default:     rdata_d = 32'h0000_0000;
    endcase
  end

  // Configuration fields as typed values
  assign gen_sel    = dsp_word_pkg::gen_t'(ctrl_q[`CTRL_GEN_LSB +: 2]);
  assign preset_sel = dsp_word_pkg::preset_t'(ctrl_q[`CTRL_PRESET_LSB +: 3]);
  assign is_custom  = (preset_sel == dsp_word_pkg::OP_CUSTOM);
  assign xy_c       = dsp_word_pkg::xy_t'(custom_q[`CUS_XY_LSB +: 4]);
  assign z_c        = dsp_word_pkg::z_t'(custom_q[`CUS_Z_LSB +: 3]);
  assign csel_c     = dsp_word_pkg::carry_t'(custom_q[`CUS_CSEL_LSB +: 3]);
  assign w_c        = dsp_word_pkg::w_t'(custom_q[`CUS_W_LSB +: 2]);

  // Preset encodings; every preset except OP_C_ONLY uses a product or A:B as X
  always_comb begin
    xy_p  = dsp_word_pkg::XY_PROD;
    z_p   = dsp_word_pkg::Z_C;
    alu_p = dsp_word_pkg::ALU_ADD;
    unique case (preset_sel)
      dsp_word_pkg::OP_C_PROD:     z_p = dsp_word_pkg::Z_C;
      dsp_word_pkg::OP_CASC_PROD:  z_p = dsp_word_pkg::Z_CASCADE;
      dsp_word_pkg::OP_P_PROD:     z_p = dsp_word_pkg::Z_P;
      dsp_word_pkg::OP_PROD:       z_p = dsp_word_pkg::Z_ZERO;
      dsp_word_pkg::OP_C_PLUS_AB:  xy_p = dsp_word_pkg::XY_AB;
      dsp_word_pkg::OP_C_MINUS_AB: begin
        xy_p  = dsp_word_pkg::XY_AB;
        alu_p = dsp_word_pkg::ALU_SUB;
      end
      dsp_word_pkg::OP_C_ONLY:     xy_p = dsp_word_pkg::XY_ZERO;
      dsp_word_pkg::OP_CUSTOM:     xy_p = dsp_word_pkg::XY_PROD;
    endcase
  end

  // Custom fields reach the encoder only under the custom choice
  assign cfg.gen       = gen_sel;
  assign cfg.xy        = is_custom ? xy_c : xy_p;
  assign cfg.z         = is_custom ? z_c : z_p;
  assign cfg.alu       = is_custom ? (custom_q[`CUS_SUB_BIT] ? dsp_word_pkg::ALU_SUB
                                                             : dsp_word_pkg::ALU_ADD) : alu_p;
  assign cfg.carry_sel = is_custom ? csel_c : dsp_word_pkg::CY_CONST;
  assign cfg.carry_bit = is_custom & custom_q[`CUS_CBIT_BIT];
  assign cfg.w         = is_custom ? w_c : dsp_word_pkg::W_ZERO;

  // Input-stage settings apply to every operation
  assign cfg.preadd_fn             = input_q[`INP_PREADD_LSB +: 4];
  assign cfg.b_stage               = input_q[`INP_BREG_BIT];
  assign cfg.preadd_operand_select = input_q[`INP_PSEL_BIT];
  assign cfg.mult_a_input_select   = input_q[`INP_AMUL_BIT];
  assign cfg.mult_b_input_select   = input_q[`INP_BMUL_BIT];
  assign cfg.a_stage               = input_q[`INP_AREG_BIT];
  assign cfg.cin                   = cin_sync_q;

  dsp_word_encoder u_encoder (
    .cfg (cfg.enc)
  );

  // Configuration registers; everything holds while ce is low
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl_q   <= `RST_CTRL;
      custom_q <= `RST_CUSTOM;
      input_q  <= `RST_INPUT;
    end else if (ce) begin
      ctrl_q   <= ctrl_d;
      custom_q <= custom_d;
      input_q  <= input_d;
    end
  end

  // Single-cycle acknowledge, dropped the cycle after it is given
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else if (ce) begin
      ack_q   <= bus_req;
      rdata_q <= rdata_d;
    end
  end

  // Carry pin: two flops before any logic looks at it
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cin_meta_q <= 1'b0;
      cin_sync_q <= 1'b0;
    end else if (ce) begin
      cin_meta_q <= carry_in_pin;
      cin_sync_q <= cin_meta_q;
    end
  end

  // Output word moves only on reconfiguration or a carry pin change
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      word_q   <= 22'h000000;
      width_q  <= `WIDTH_FIRST;
      cport_q  <= 1'b0;
      negate_q <= 1'b0;
    end else if (ce) begin
      word_q   <= cfg.word;
      width_q  <= gen_width(gen_sel);
      cport_q  <= (cfg.carry_sel == dsp_word_pkg::CY_EXTERNAL);
      negate_q <= ctrl_q[`CTRL_NEGATE_BIT] & (gen_sel == dsp_word_pkg::GEN_THIRD);
    end
  end

  // Drive the ports
  assign dat_o           = rdata_q;
  assign ack_o           = ack_q;
  assign instr_word      = word_q;
  assign word_width      = width_q;
  assign carry_port_used = cport_q;
  assign mult_negate     = negate_q;

endmodule : dsp_slice_instruction_word_gen

// File: testbench/slice_ctrl_model.sv
// Far-side model: slice control inputs splitting the instruction word into fields
`timescale 1ns/1ps
module slice_ctrl_model (
  // Word from the generator
  input  wire logic [21:0] instr_word,
  input  wire logic [4:0]  word_width,
  // Selections as the slice sees them
  output logic      [3:0]  xy_sel,
  output logic      [2:0]  z_sel,
  output logic      [3:0]  alu_fn,
  output logic             carry_val,
  output logic      [2:0]  carry_src,
  output logic      [6:0]  stage_bits
);
  // Low fields are common to every generation
  assign xy_sel    = instr_word[3:0];
  assign z_sel     = instr_word[6:4];
  assign alu_fn    = instr_word[10:7];
  assign carry_val = instr_word[11];
  assign carry_src = instr_word[14:12];
  // Oldest slice has no input-stage bits, so anything up there is ignored
  assign stage_bits = (word_width == 5'h0F) ? 7'h00 : instr_word[21:15];
endmodule : slice_ctrl_model

// File: testbench/word_gen_sva.sv
// Checker for the instruction word generator ports
`timescale 1ns/1ps
`include "dsp_word_map.svh"
module word_gen_sva (
  // Clock, reset and enable
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic        ce,
  // Register bus
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // Carry pin and slice outputs
  input wire logic        carry_in_pin,
  input wire logic [21:0] instr_word,
  input wire logic [4:0]  word_width,
  input wire logic        carry_port_used,
  input wire logic        mult_negate
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // Request steps
  sequence s_taken;
    cyc_i && stb_i && ce && !ack_o;
  endsequence
  sequence s_write_held;
    cyc_i && stb_i && we_i;
  endsequence
  // Width and outputs load on the same edge; the $stable guards still skip the cycle of a change
  chk_ack_answer: assert property (s_taken |=> ack_o) else $error("ack missing");
  chk_ack_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i)) else $error("ack without request");
  chk_ack_drop: assert property (ack_o && ce |=> !ack_o) else $error("ack longer than one cycle");
  chk_width_legal: assert property (word_width inside {`WIDTH_FIRST, `WIDTH_SECOND, `WIDTH_THIRD})
    else $error("bad word width");
  chk_upper_zero: assert property ($stable(word_width) && $stable(instr_word) |->
    (instr_word >> word_width) == 22'h000000) else $error("bits above width set");
  chk_negate_third: assert property ($stable(word_width) && mult_negate |-> word_width == `WIDTH_THIRD)
    else $error("negate outside newest generation");
  chk_carry_flag: assert property ($stable(instr_word) |-> carry_port_used == (instr_word[14:12] == 3'h1))
    else $error("carry port flag wrong");
  chk_alu_code: assert property (instr_word[10:7] == 4'h0 || instr_word[10:7] == 4'h3)
    else $error("bad function code");
  chk_field_codes: assert property (instr_word[3:0] <= 4'h6 && instr_word[6:4] <= 3'h5
    && instr_word[14:12] != 3'h7) else $error("bad field code");
  chk_static_word: assert property ({instr_word[21:12], instr_word[10:0]} !=
    $past({instr_word[21:12], instr_word[10:0]}) |-> $past(s_write_held) || $past(srst) || $past(srst, 2))
    else $error("word changed without a write");
endmodule : word_gen_sva
bind dsp_slice_instruction_word_gen word_gen_sva u_word_gen_sva (.clk_sys(clk_sys), .srst(srst), .ce(ce),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
  .ack_o(ack_o), .carry_in_pin(carry_in_pin), .instr_word(instr_word), .word_width(word_width),
  .carry_port_used(carry_port_used), .mult_negate(mult_negate));

// File: testbench/dsp_slice_instruction_word_gen_bench.sv
// Self-checking bench for the instruction word generator
`timescale 1ns/1ps
`include "dsp_word_map.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module dsp_slice_instruction_word_gen_bench;
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic        ce = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'hF;
  logic [31:0] dat_i = 32'h00000000;
  logic        carry_in_pin = 1'b0;
  logic [31:0] dat_o, rd;
  logic        ack_o, carry_port_used, mult_negate, carry_val;
  logic [21:0] instr_word;
  logic [4:0]  word_width;
  logic [3:0]  xy_sel, alu_fn;
  logic [2:0]  z_sel, carry_src;
  logic [6:0]  stage_bits;
  logic [3:0]  wsel = 4'hF;
  int          err_total = 0;
  int          num_checks = 0;
  logic [21:0] preset_word [6] = '{22'h000033, 22'h000013, 22'h000023, 22'h000003, 22'h000032, 22'h0001B2};
  always #12.5 clk_sys = ~clk_sys;
  dsp_slice_instruction_word_gen u_dsp_slice_instruction_word_gen (.clk_sys(clk_sys), .srst(srst), .ce(ce),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .carry_in_pin(carry_in_pin), .instr_word(instr_word), .word_width(word_width),
    .carry_port_used(carry_port_used), .mult_negate(mult_negate));
  slice_ctrl_model u_slice_ctrl_model (.instr_word(instr_word), .word_width(word_width), .xy_sel(xy_sel),
    .z_sel(z_sel), .alu_fn(alu_fn), .carry_val(carry_val), .carry_src(carry_src), .stage_bits(stage_bits));
  // Custom register image from field values
  function automatic logic [31:0] cus(input logic [3:0] xy, input logic [2:0] z, input logic sb,
                                      input logic cb, input logic [2:0] cs, input logic [1:0] w);
    cus = {14'h0000, w, 1'b0, cs, cb, 3'h0, sb, z, xy};
  endfunction : cus
  // One classic cycle; the timeout bounds a slave that never answers
  task automatic wb_cycle(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= wsel;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) err_total++;
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_sys);
  endtask : wb_cycle
  task automatic wb_write(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_cycle(a, 1'b1, d, q);
    repeat (2) @(posedge clk_sys);
  endtask : wb_write
  task automatic wb_read(input logic [7:0] a, output logic [31:0] q);
    wb_cycle(a, 1'b0, 32'h00000000, q);
  endtask : wb_read
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  // Watchdog well beyond the roughly 120 cycles the tests need
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_total++;
    close_out();
  end
  // Test sequence
  initial begin
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    `CHK("reset word", 22'h000033, instr_word)
    `CHK("reset width", `WIDTH_FIRST, word_width)
    wb_read(`REG_STATUS, rd);
    `CHK("status", 32'h0000000F, rd)
    $display("test reset done");
    // Custom fields loaded but presets must ignore them
    wb_write(`REG_CUSTOM, cus(4'h6, 3'h5, 1'b1, 1'b1, 3'h6, 2'h0));
    for (int i = 0; i < 6; i++) begin
      wb_write(`REG_CTRL, 32'(i) << `CTRL_PRESET_LSB);
      `CHK("preset", preset_word[i], instr_word)
    end
    wb_write(`REG_CTRL, 32'h00000060);
    `CHK("c only", 8'h00, instr_word[14:7])
    wb_write(`REG_CTRL, 32'h00000070);
    `CHK("custom", 22'h0069D6, instr_word)
    `CHK("alu", 4'h3, alu_fn)
    $display("test presets done");
    // Illegal XY code refused so the old XY stays, low byte lane only
    wsel = 4'h1;
    wb_write(`REG_CUSTOM, cus(4'h7, 3'h2, 1'b0, 1'b0, 3'h0, 2'h0));
    wsel = 4'hF;
    `CHK("xy kept", 4'h6, xy_sel)
    `CHK("z", 3'h2, z_sel)
    `CHK("lane", 3'h6, carry_src)
    // External carry pin into bit 11
    wb_write(`REG_CUSTOM, cus(4'h3, 3'h3, 1'b0, 1'b0, 3'h1, 2'h0));
    carry_in_pin <= 1'b1;
    repeat (5) @(posedge clk_sys);
    `CHK("cport", 1'b1, carry_port_used)
    `CHK("cin high", 1'b1, carry_val)
    carry_in_pin <= 1'b0;
    repeat (5) @(posedge clk_sys);
    `CHK("cin low", 1'b0, carry_val)
    $display("test fields done");
    // Second generation input stage
    wb_write(`REG_CUSTOM, cus(4'h3, 3'h3, 1'b0, 1'b0, 3'h0, 2'h2));
    wb_write(`REG_CTRL, 32'h00000071);
    wb_write(`REG_INPUT, 32'h00000019);
    `CHK("width2", `WIDTH_SECOND, word_width)
    `CHK("stage2", 7'h13, stage_bits)
    // Newest generation with negate and W source
    wb_write(`REG_INPUT, 32'h00000B00);
    wb_write(`REG_CTRL, 32'h00000173);
    `CHK("width3", `WIDTH_THIRD, word_width)
    `CHK("stage3", 7'h5A, stage_bits)
    `CHK("negate", 1'b1, mult_negate)
    wb_write(`REG_CTRL, 32'h00000171);
    `CHK("negate2", 1'b0, mult_negate)
    `CHK("no a stage", 7'h00, stage_bits)
    wb_write(`REG_CTRL, 32'h00000072);
    `CHK("gen code2", `WIDTH_FIRST, word_width)
    $display("test generations done");
    // Read-only and unmapped places
    wb_write(`REG_WORD, 32'hFFFFFFFF);
    wb_read(`REG_WORD, rd);
    `CHK("word ro", 32'h00000033, rd)
    wb_read(8'h20, rd);
    `CHK("unmapped", 32'h00000000, rd)
    $display("test bus done");
    close_out();
  end
endmodule : dsp_slice_instruction_word_gen_bench
